// ---- logic/dmrc_pkg.sv ----
package dmrc_pkg;
    // ==========================================
    // Command pin encoding
    localparam int ADDR_W = 16;
    localparam int BA_W = 3;
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;
    localparam logic [2:0] BA_MR2 = 3'h2;
    // ==========================================
    // Mode register 0 fields
    localparam int MR0_CL0 = 2;
    localparam int MR0_CL_LO = 4;
    localparam int MR0_CL_HI = 6;
    localparam int MR0_TEST = 7;
    localparam int MR0_DLLRST = 8;
    localparam int MR0_WR_LO = 9;
    localparam int MR0_WR_HI = 11;
    localparam int MR0_PPD = 12;
    // ==========================================
    // Mode register 1 fields
    localparam int MR1_DLLDIS = 0;
    localparam int MR1_DRV0 = 1;
    localparam int MR1_RTT0 = 2;
    localparam int MR1_AL_LO = 3;
    localparam int MR1_AL_HI = 4;
    localparam int MR1_DRV1 = 5;
    localparam int MR1_RTT1 = 6;
    localparam int MR1_WLVL = 7;
    localparam int MR1_RTT2 = 9;
    localparam int MR1_QOFF = 12;
    // ==========================================
    // Mode register 2 fields
    localparam int MR2_PARTIAL_ARRAY_SELF_REFRESH_LO = 0;
    localparam int MR2_PARTIAL_ARRAY_SELF_REFRESH_HI = 2;
    localparam int MR2_CWL_LO = 3;
    localparam int MR2_CWL_HI = 5;
    localparam int MR2_RTTWR_LO = 9;
    localparam int MR2_RTTWR_HI = 10;
    // ==========================================
    // Reset values and counts
    localparam logic [15:0] MR_RESET = 16'h0000;
    localparam int CL_BASE = 4;
    localparam int CWL_BASE = 5;
    localparam int DLL_RESET_CYCLES = 4;
    localparam int SYNC_STAGES = 3;
endpackage

// ---- logic/dmrc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmrc_sync
    import dmrc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out,
    output logic [WIDTH-1:0] rise
);
    // ==========================================
    // Three stages; change accepted when two and three agree
    logic [WIDTH-1:0] s1, s2, s3, held;
    logic [WIDTH-1:0] next_held;

    always_comb begin
        next_held = held;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2[i] == s3[i]) begin
                next_held[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            held <= '0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            held <= next_held;
        end
    end

    assign sync_out = held;
    assign rise = next_held & ~held;
endmodule
`default_nettype wire

// ---- logic/dmrc_top.sv ----
// How it works
// (R1) Read CAS latency decoded from mode_reg_0 bits A2, A4, A5, A6, whole cycles.
// (R2) Controller keeps mode_reg_0 A7 zero; test mode has undefined behaviour.
// (R3) DLL-reset bit clears itself once the DLL reset has been carried out.
// (R4) Controller waits DLL lock time after DLL reset before reads.
// (R5) Write recovery field A9..A11 plus precharge time gives autoprecharge write delay.
// (R6) Controller programs write recovery at least ceil of recovery time over clock.
// (R7) A12 zero: DLL frozen in precharge power-down, slow exit.
// (R8) A12 one: DLL kept running in precharge power-down, fast exit.
// (R9) Mode set with BA=001 writes mode_reg_1, BA=010 writes mode_reg_2.
// (R10) Controller drives reserved bits of mode_reg_1 and mode_reg_2 to zero.
// (R11) Write leveling with outputs on allows only RZQ/2, /4, /6 nominal termination.
// (R12) DLL enabled: DLL off in self refresh, back on at exit.
// (R13) Controller holds clock enable high throughout DLL lock period.
// (R14) DLL-off mode: controller disables nominal termination.
// (R15) DLL-off mode: controller writes dynamic termination bits to zero.
// (R16) Driver impedance selected by mode_reg_1 bits A1 and A5.
// (R17) Write termination applies during writes even with nominal termination off.
// (R18) Reads and writes held for additive latency; write latency is additive plus CAS_WRITE_LATENCY.
// (R19) Additive latency: 00 off, 01 CL-1, 10 CL-2, 11 reserved.
// (R20) mode_reg_1 A12 set disconnects all data and strobe outputs.
// (R21) No dynamic write termination while write leveling is active.
// (R22) Partial array self refresh limits retained range during self refresh.
// (R23) Mode set with all bank-address bits low writes mode_reg_0.
// (R24) CAS write latency from mode_reg_2 bits A3..A5, whole cycles.
`timescale 1ns/1ps
`default_nettype none
module dmrc_top
    import dmrc_pkg::*;
#(
    parameter int DLL_RESET_LEN = DLL_RESET_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ck_link,
    input wire logic cke,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic [BA_W-1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic self_refresh,
    input wire logic precharge_pd,
    input wire logic write_active,
    input wire logic termination_pin,
    output logic [ADDR_W-1:0] mode_reg_0,
    output logic [ADDR_W-1:0] mode_reg_1,
    output logic [ADDR_W-1:0] mode_reg_2,
    output logic [4:0] read_cas_latency,
    output logic [4:0] cas_write_latency,
    output logic [4:0] additive_latency,
    output logic [5:0] read_latency_total,
    output logic [5:0] write_latency_total,
    output logic [3:0] write_recovery,
    output logic dll_reset_busy,
    output logic dll_running,
    output logic fast_pd_exit,
    output logic [1:0] drive_strength,
    output logic [2:0] rtt_nom_sel,
    output logic [1:0] rtt_applied,
    output logic outputs_off,
    output logic write_leveling,
    output logic [2:0] partial_array_self_refresh,
    output logic test_mode
);
    // ==========================================
    // Pin sampling: link clock and command pins cross in
    localparam int NPIN = 7 + BA_W + ADDR_W;
    logic [NPIN-1:0] pin_sync;
    logic ck_rise;

    dmrc_sync #(.WIDTH(1)) u_ck (
        .clock(clock),
        .rst_b(rst_b),
        .async_in(ck_link),
        .sync_out(),
        .rise(ck_rise)
    );

    // Pins held stable around the link clock edge, so sampled alongside it
    dmrc_sync #(.WIDTH(NPIN)) u_pins (
        .clock(clock),
        .rst_b(rst_b),
        .async_in({cke, cs_b, ras_b, cas_b, we_b, ba, addr, self_refresh, precharge_pd}),
        .sync_out(pin_sync),
        .rise()
    );

    logic s_cke, s_cs_b, s_ras_b, s_cas_b, s_we_b, s_sr, s_ppd;
    logic [BA_W-1:0] s_ba;
    logic [ADDR_W-1:0] s_addr;
    assign {s_cke, s_cs_b, s_ras_b, s_cas_b, s_we_b, s_ba, s_addr, s_sr, s_ppd} = pin_sync;

    // ==========================================
    // Functions
    function automatic logic [4:0] cl_decode(input logic [3:0] code);
        cl_decode = 5'(CL_BASE) + 5'(code[3:1]) + (code[0] ? 5'h08 : 5'h00);
    endfunction

    function automatic logic [4:0] al_decode(input logic [1:0] code, input logic [4:0] cl);
        case (code)
            2'h1: al_decode = cl - 5'h01;
            2'h2: al_decode = cl - 5'h02;
            default: al_decode = 5'h00; // Reserved code treated as off
        endcase
    endfunction

    // ==========================================
    // Mode register set decode
    logic mrs_cmd;
    assign mrs_cmd = ck_rise && s_cke && !s_cs_b && !s_ras_b && !s_cas_b && !s_we_b;

    typedef enum logic [2:0] {
        DMRC_IDLE = 3'b001,
        DMRC_DLLRST = 3'b010,
        DMRC_SREF = 3'b100
    } dmrc_state_e;

    dmrc_state_e state, next_state;
    logic [ADDR_W-1:0] next_mr0, next_mr1, next_mr2;
    logic [7:0] rst_cnt, next_rst_cnt;

    always_comb begin
        next_mr0 = mode_reg_0;
        next_mr1 = mode_reg_1;
        next_mr2 = mode_reg_2;
        next_state = state;
        next_rst_cnt = rst_cnt;
        if (mrs_cmd) begin
            case (s_ba)
                BA_MR0: next_mr0 = s_addr; // [R23]
                BA_MR1: next_mr1 = s_addr; // [R9]
                BA_MR2: next_mr2 = s_addr; // [R9]
                default: next_mr0 = mode_reg_0;
            endcase
        end
        case (state)
            DMRC_IDLE: begin
                if (s_sr && !mode_reg_1[MR1_DLLDIS]) begin
                    next_state = DMRC_SREF; // [R12]
                end else if (mode_reg_0[MR0_DLLRST]) begin
                    next_state = DMRC_DLLRST;
                    next_rst_cnt = 8'(DLL_RESET_LEN);
                end
            end
            DMRC_DLLRST: begin
                if (rst_cnt <= 8'h01) begin
                    next_state = DMRC_IDLE;
                    next_rst_cnt = 8'h00;
                    // Fresh mode_reg_0 write wins, so a new reset request is never lost
                    if (!(mrs_cmd && s_ba == BA_MR0)) begin
                        next_mr0[MR0_DLLRST] = 1'b0; // [R3]
                    end
                end else begin
                    next_rst_cnt = rst_cnt - 8'h01;
                end
            end
            DMRC_SREF: begin
                if (!s_sr) begin
                    next_state = DMRC_IDLE; // [R12]
                end
            end
            default: next_state = DMRC_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mode_reg_0 <= MR_RESET;
            mode_reg_1 <= MR_RESET;
            mode_reg_2 <= MR_RESET;
            state <= DMRC_IDLE;
            rst_cnt <= 8'h00;
        end else begin
            mode_reg_0 <= next_mr0;
            mode_reg_1 <= next_mr1;
            mode_reg_2 <= next_mr2;
            state <= next_state;
            rst_cnt <= next_rst_cnt;
        end
    end

    // ==========================================
    // Decoded fields: latencies, recovery, DLL and termination registered; mode bits below assigned directly
    logic [4:0] next_cl, next_cwl, next_al;
    logic [3:0] next_wr;
    logic next_dll_run, next_busy;
    logic [1:0] next_rtt;

    always_comb begin
        next_cl = cl_decode({mode_reg_0[MR0_CL_HI:MR0_CL_LO], mode_reg_0[MR0_CL0]}); // [R1]
        next_al = al_decode(mode_reg_1[MR1_AL_HI:MR1_AL_LO], next_cl); // [R19] [R18]
        next_cwl = 5'(CWL_BASE) + 5'(mode_reg_2[MR2_CWL_HI:MR2_CWL_LO]); // [R24]
        // Code zero gives a write_recovery of zero
        next_wr = (mode_reg_0[MR0_WR_HI:MR0_WR_LO] == 3'h0) ? 4'h0 :
                  (mode_reg_0[MR0_WR_HI:MR0_WR_LO] < 3'h4) ? 4'(mode_reg_0[MR0_WR_HI:MR0_WR_LO] + 3'h4) :
                  4'({mode_reg_0[MR0_WR_HI:MR0_WR_LO], 1'b0}); // [R5]
        // Frozen when disabled, in self refresh, or slow-exit power-down
        next_dll_run = !mode_reg_1[MR1_DLLDIS] && (state != DMRC_SREF) &&
                       !(s_ppd && !mode_reg_0[MR0_PPD]); // [R7] [R8] [R12]
        next_busy = (state == DMRC_DLLRST);
        // Write leveling blocks dynamic termination
        if (termination_pin && write_active && !mode_reg_1[MR1_WLVL] &&
                mode_reg_2[MR2_RTTWR_HI:MR2_RTTWR_LO] != 2'h0) begin
            next_rtt = mode_reg_2[MR2_RTTWR_HI:MR2_RTTWR_LO]; // [R17] [R21]
        end else begin
            next_rtt = 2'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            read_cas_latency <= 5'h00;
            cas_write_latency <= 5'h00;
            additive_latency <= 5'h00;
            read_latency_total <= 6'h00;
            write_latency_total <= 6'h00;
            write_recovery <= 4'h0;
            dll_running <= 1'b0;
            dll_reset_busy <= 1'b0;
            rtt_applied <= 2'h0;
        end else begin
            read_cas_latency <= next_cl;
            cas_write_latency <= next_cwl;
            additive_latency <= next_al;
            read_latency_total <= 6'(next_al) + 6'(next_cl); // [R1]
            write_latency_total <= 6'(next_al) + 6'(next_cwl); // [R18]
            write_recovery <= next_wr;
            dll_running <= next_dll_run;
            dll_reset_busy <= next_busy;
            rtt_applied <= next_rtt;
        end
    end

    assign fast_pd_exit = mode_reg_0[MR0_PPD]; // [R8]
    assign drive_strength = {mode_reg_1[MR1_DRV1], mode_reg_1[MR1_DRV0]}; // [R16]
    assign rtt_nom_sel = {mode_reg_1[MR1_RTT2], mode_reg_1[MR1_RTT1], mode_reg_1[MR1_RTT0]};
    assign outputs_off = mode_reg_1[MR1_QOFF]; // [R20]
    assign write_leveling = mode_reg_1[MR1_WLVL];
    assign partial_array_self_refresh = mode_reg_2[MR2_PARTIAL_ARRAY_SELF_REFRESH_HI:MR2_PARTIAL_ARRAY_SELF_REFRESH_LO]; // [R22]
    assign test_mode = mode_reg_0[MR0_TEST]; // [R2]

    // ==========================================
    // Assertions
    a_dllrst_clears: assert property (@(posedge clock) disable iff (!rst_b) // [R3]
        (state == DMRC_DLLRST && rst_cnt == 8'h01 && !(mrs_cmd && s_ba == BA_MR0))
        |=> !mode_reg_0[MR0_DLLRST])
        else $error("dll reset bit not cleared");
    a_mr1_target: assert property (@(posedge clock) disable iff (!rst_b) // [R9]
        (mrs_cmd && s_ba == BA_MR1) |=> mode_reg_1 == $past(s_addr))
        else $error("mode_reg_1 not written");
    a_mr2_target: assert property (@(posedge clock) disable iff (!rst_b) // [R9]
        (mrs_cmd && s_ba == BA_MR2) |=> mode_reg_2 == $past(s_addr))
        else $error("mode_reg_2 not written");
    a_mr0_target: assert property (@(posedge clock) disable iff (!rst_b) // [R23]
        (mrs_cmd && s_ba == BA_MR0) |=> mode_reg_0 == $past(s_addr))
        else $error("mode_reg_0 not written");
    a_rl_sum: assert property (@(posedge clock) disable iff (!rst_b) // [R1]
        ##1 read_latency_total == 6'(additive_latency) + 6'(read_cas_latency))
        else $error("read latency sum wrong");
    a_al_decode: assert property (@(posedge clock) disable iff (!rst_b) // [R19]
        $past(mode_reg_1[MR1_AL_HI:MR1_AL_LO]) == 2'h2 && $past(mode_reg_0) == mode_reg_0
        |-> additive_latency == read_cas_latency - 5'h02)
        else $error("additive latency decode wrong");
    a_wl_sum: assert property (@(posedge clock) disable iff (!rst_b) // [R18]
        ##1 write_latency_total == 6'(additive_latency) + 6'(cas_write_latency))
        else $error("write latency sum wrong");
    a_sref_dll_off: assert property (@(posedge clock) disable iff (!rst_b) // [R12]
        state == DMRC_SREF |=> !dll_running)
        else $error("dll running in self refresh");
    a_slow_pd: assert property (@(posedge clock) disable iff (!rst_b) // [R7]
        (s_ppd && !mode_reg_0[MR0_PPD]) |=> !dll_running)
        else $error("dll not frozen in slow exit");
    a_no_dyn_wlvl: assert property (@(posedge clock) disable iff (!rst_b) // [R21]
        mode_reg_1[MR1_WLVL] |=> rtt_applied == 2'h0)
        else $error("dynamic termination in write leveling");
endmodule
`default_nettype wire

// ---- tb/dmrc_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Controller side issuing mode register sets
module dmrc_ctrl_model
    import dmrc_pkg::*;
(
    output logic ck_link,
    output logic cke,
    output logic cs_b,
    output logic ras_b,
    output logic cas_b,
    output logic we_b,
    output logic [BA_W-1:0] ba,
    output logic [ADDR_W-1:0] addr
);
    initial begin
        ck_link = 1'b0;
        cke = 1'b1;
        {cs_b, ras_b, cas_b, we_b} = 4'hf;
        ba = 3'h7;
        addr = 16'hffff;
    end

    // Link clock only pulses inside a frame; pins held 24 ns either side
    task automatic mode_reg_set_command(input logic [BA_W-1:0] sel, input logic [ADDR_W-1:0] val);
        logic [ADDR_W-1:0] v;
        v = val;
        if (sel == BA_MR0) v[MR0_TEST] = 1'b0;
        // Bits A8, A10, A11 of mode_reg_1 and A8, A11, A12 of mode_reg_2 forced to zero
        if (sel == BA_MR1) v = v & 16'hf2ff;
        if (sel == BA_MR2) v = v & 16'he6ff;
        {cs_b, ras_b, cas_b, we_b} = 4'h0;
        ba = sel;
        addr = v;
        #24;
        ck_link = 1'b1;
        #24;
        ck_link = 1'b0;
        #24;
        // Released lines show the inverse, not a stale copy
        {cs_b, ras_b, cas_b, we_b} = 4'hf;
        ba = ~sel;
        addr = ~v;
    endtask
endmodule
`default_nettype wire

// ---- tb/dmrc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmrc_top_tb
    import dmrc_pkg::*;
;
    localparam int DLL_LEN = 6;
    logic clock, rst_b, ck_link, cke, cs_b, ras_b, cas_b, we_b;
    logic self_refresh, precharge_pd, write_active, termination_pin;
    logic [2:0] ba;
    logic [15:0] addr, mode_reg_0, mode_reg_1, mode_reg_2;
    logic [4:0] read_cas_latency, cas_write_latency, additive_latency;
    logic [5:0] read_latency_total, write_latency_total;
    logic [3:0] write_recovery;
    logic dll_reset_busy, dll_running, fast_pd_exit, outputs_off, write_leveling, test_mode;
    logic [1:0] drive_strength, rtt_applied;
    logic [2:0] rtt_nom_sel, partial_array_self_refresh;
    logic [15:0] e [0:2];
    logic [3:0] wr_tab [0:7] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'he};
    int num_errors = 0;
    int num_checks = 0;

    dmrc_top #(.DLL_RESET_LEN(DLL_LEN)) dmrc_top_inst (.clock(clock), .rst_b(rst_b), .ck_link(ck_link),
        .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr),
        .self_refresh(self_refresh), .precharge_pd(precharge_pd), .write_active(write_active),
        .termination_pin(termination_pin), .mode_reg_0(mode_reg_0), .mode_reg_1(mode_reg_1),
        .mode_reg_2(mode_reg_2), .read_cas_latency(read_cas_latency), .cas_write_latency(cas_write_latency),
        .additive_latency(additive_latency), .read_latency_total(read_latency_total),
        .write_latency_total(write_latency_total), .write_recovery(write_recovery),
        .dll_reset_busy(dll_reset_busy), .dll_running(dll_running), .fast_pd_exit(fast_pd_exit),
        .drive_strength(drive_strength), .rtt_nom_sel(rtt_nom_sel), .rtt_applied(rtt_applied),
        .outputs_off(outputs_off), .write_leveling(write_leveling),
        .partial_array_self_refresh(partial_array_self_refresh), .test_mode(test_mode));
    dmrc_ctrl_model dmrc_ctrl_model_inst (.ck_link(ck_link), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
        .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr));

    initial clock = 1'b0;
    always #2.5 clock = ~clock;

    // ==========================================
    // Shared tasks
    function automatic logic [4:0] cl_of(input logic [15:0] a);
        return 5'h04 + {2'h0, a[6:4]} + {1'h0, a[2], 3'h0};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Every write also proves that the other two registers stayed put
    task automatic w(input logic [2:0] sel, input logic [15:0] val);
        dmrc_ctrl_model_inst.mode_reg_set_command(sel, val);
        if (sel < 3'h3) e[sel[1:0]] = val & 16'hfeff;
        repeat (10) @(negedge clock);
        chk(mode_reg_0, e[0]);
        chk(mode_reg_1, e[1]);
        chk(mode_reg_2, e[2]);
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        repeat (2) @(negedge clock);
        chk(read_cas_latency, 5'h04);
        chk(cas_write_latency, 5'h05);
        chk(additive_latency, 5'h00);
        $display("Test reset done");
    endtask

    task automatic t_mr0();
        logic [15:0] v [0:3] = '{16'h1234, 16'h0e74, 16'h0850, 16'h0020};
        for (int i = 0; i < 4; i++) begin
            w(BA_MR0, v[i]);
            chk(read_cas_latency, cl_of(v[i]));
            chk(write_recovery, wr_tab[v[i][11:9]]);
            chk(fast_pd_exit, v[i][12]);
            chk(test_mode, 1'h0);
        end
        $display("Test mode_reg_0 done");
    endtask

    task automatic t_mr1();
        logic [15:0] v [0:3] = '{16'h1002, 16'h0048, 16'h0234, 16'h0018};
        logic [4:0] a;
        for (int i = 0; i < 4; i++) begin
            w(BA_MR1, v[i]);
            a = (v[i][4:3] == 2'h1) ? cl_of(e[0]) - 5'h01 : (v[i][4:3] == 2'h2) ? cl_of(e[0]) - 5'h02 : 5'h00;
            chk(additive_latency, a);
            chk(read_latency_total, a + cl_of(e[0]));
            chk(drive_strength, {v[i][5], v[i][1]});
            chk(outputs_off, v[i][12]);
            chk(rtt_nom_sel, {v[i][9], v[i][6], v[i][2]});
        end
        $display("Test mode_reg_1 done");
    endtask

    task automatic t_mr2();
        logic [2:0] k [0:2] = '{3'h0, 3'h7, 3'h3};
        w(BA_MR1, 16'h0008);
        for (int i = 0; i < 3; i++) begin
            w(BA_MR2, {10'h000, k[i], k[i]});
            chk(cas_write_latency, 5'h05 + k[i]);
            chk(write_latency_total, cl_of(e[0]) - 16'h0001 + 16'h0005 + k[i]);
            chk(partial_array_self_refresh, k[i]);
        end
        $display("Test mode_reg_2 done");
    endtask

    task automatic t_rtt();
        w(BA_MR1, 16'h0000);
        w(BA_MR2, 16'h0200);
        write_active = 1'b1;
        termination_pin = 1'b1;
        repeat (2) @(negedge clock);
        chk(rtt_applied, 2'h1);
        w(BA_MR1, 16'h0080);
        chk(write_leveling, 1'h1);
        chk(rtt_applied, 2'h0);
        write_active = 1'b0;
        termination_pin = 1'b0;
        w(BA_MR1, 16'h0000);
        w(3'h3, 16'h0aaa);
        w(3'h7, 16'h0555);
        $display("Test termination and ignored banks done");
    endtask

    task automatic t_dll();
        int cnt;
        logic busy;
        cnt = 0;
        busy = 1'b0;
        fork
            dmrc_ctrl_model_inst.mode_reg_set_command(BA_MR0, 16'h0100);
            begin
                for (int n = 0; n < 40 && mode_reg_0[MR0_DLLRST] !== 1'b1; n++) @(negedge clock);
                while (mode_reg_0[MR0_DLLRST] === 1'b1 && cnt < 40) begin
                    if (dll_reset_busy === 1'b1) busy = 1'b1;
                    cnt++;
                    @(negedge clock);
                end
            end
        join
        chk(16'(cnt), 16'(DLL_LEN + 1));
        chk(busy, 1'h1);
        e[0] = 16'h0000;
        repeat (10) @(negedge clock);
        chk(mode_reg_0, 16'h0000);
        chk(dll_reset_busy, 1'h0);
        $display("Test dll reset done");
    endtask

    task automatic t_power();
        chk(dll_running, 1'h1);
        self_refresh = 1'b1;
        repeat (8) @(negedge clock);
        chk(dll_running, 1'h0);
        self_refresh = 1'b0;
        repeat (8) @(negedge clock);
        chk(dll_running, 1'h1);
        precharge_pd = 1'b1;
        repeat (8) @(negedge clock);
        chk(dll_running, 1'h0);
        w(BA_MR0, 16'h1000);
        chk(dll_running, 1'h1);
        precharge_pd = 1'b0;
        w(BA_MR2, 16'h0000);
        w(BA_MR1, 16'h0001);
        chk(dll_running, 1'h0);
        chk(rtt_nom_sel, 3'h0);
        self_refresh = 1'b1;
        repeat (8) @(negedge clock);
        chk(dll_running, 1'h0);
        self_refresh = 1'b0;
        w(BA_MR1, 16'h0000);
        chk(dll_running, 1'h1);
        $display("Test power modes done");
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial begin
        rst_b = 1'b0;
        self_refresh = 1'b0;
        precharge_pd = 1'b0;
        write_active = 1'b0;
        termination_pin = 1'b0;
        e = '{16'h0000, 16'h0000, 16'h0000};
        repeat (3) @(negedge clock);
        rst_b = 1'b1;
        t_reset();
        t_mr0();
        t_mr1();
        t_mr2();
        t_rtt();
        t_dll();
        t_power();
        report_and_stop();
    end

    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
